// *** rtl/accel_code_adjust.v ***
// Self-test offset stage for the selected acceleration code
`timescale 1ns/1ps
`include "accel_readout_consts.vh"
module accel_code_adjust #(
    parameter [11:0] ST_SHIFT = `ST_DELTA
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [11:0] raw_code,
    input  wire        self_test,
    output reg  [11:0] adj_code
);

// ==========================================================
// Offset with saturation
// ==========================================================
wire [12:0] sum_w;          // Raw code plus self-test shift, one spare bit
assign sum_w = {1'b0, raw_code} + {1'b0, ST_SHIFT};

// Self-test lifts the reading, clipped at the top code
always @(posedge sys_clk) begin
    if (!rst_n) begin
        adj_code <= `ZERO_G_CODE;
    end else if (self_test) begin
        adj_code <= sum_w[12] ? `FULL_CODE : sum_w[11:0];
    end else begin
        adj_code <= raw_code;
    end
end

endmodule

// *** rtl/accel_readout_consts.vh ***
// Constants for the dual-axis accelerometer serial readout
`ifndef ACCEL_READOUT_CONSTS_VH
`define ACCEL_READOUT_CONSTS_VH

// ==========================================================
// Frame geometry
// ==========================================================
`define FRAME_CLKS       16          // Serial clocks per accelerometer frame
`define CNT_W            4           // Width of the rising-edge counter
`define ACC_LEAD_ZEROS   4'h4        // Leading zero bits ahead of the sample
`define ACC_MSB_INDEX    4'hF        // Bit index that maps to sample bit 0
`define TMP_LAST_INDEX   4'hA        // Bit index of the last temperature bit
`define TMP_BITS         10          // Temperature data width

// ==========================================================
// Edge positions, counted as rising edges seen before this one
// ==========================================================
`define SAMPLE_RISE      4'h1        // Second rising edge samples the axis
`define CTRL_LOAD_RISE   4'h7        // Eighth rising edge completes the word
`define LAST_RISE        4'hF        // Sixteenth rising edge closes the frame

// ==========================================================
// Control word layout
// ==========================================================
`define CTRL_BITS        8
`define AXIS_BIT         3           // 0 = X axis, 1 = Y axis
`define PM_BIT           0           // 0 = normal, 1 = shutdown
`define CTRL_RESET       8'h04       // X axis, normal mode, fixed one bit set
`define TCTRL_RESET      8'h00       // Temperature control word after reset

// ==========================================================
// Sample coding
// ==========================================================
`define SAMPLE_W         12
`define ZERO_G_CODE      12'h800     // Zero acceleration
`define PLUS_5G_CODE     12'hD00     // Plus five g
`define MINUS_5G_CODE    12'h300     // Minus five g
`define FULL_CODE        12'hFFF     // Saturation ceiling
`define ST_DELTA         12'h0CD     // Self-test shift, 205 codes

`endif

// *** rtl/accel_serial_readout.v ***
// Serial slave port of a dual-axis accelerometer with temperature readout
//
// Operation
// - Samples are 12-bit offset binary, 0x800 zero.
// - Self-test raises reading by 205 codes.
// - Select fall starts conversion and transfer.
// - Axis sampled on second rising clock edge.
// - Accelerometer frame takes sixteen serial clocks.
// - Select rise releases data output.
// - Select held low restarts next frame.
// - Control bit 3 chooses X or Y.
// - Control bit 0 selects shutdown.
// - Shutdown entered at load; word retained.
// - Wake from shutdown on sixteenth rise.
// - Temperature select gates clock; zero plus ten.
// - Hold last temperature bit until release.
// - Temperature control bits captured on rises.
// - Output bits change on falling clock edges.
// - Temperature is twos complement, quarter degree.
//
// Limitations
// Sensor codes are taken as quasi-static words.
// Temperature conversion timing is not modelled.
`timescale 1ns/1ps
`include "accel_readout_consts.vh"
module accel_serial_readout (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        temp_select_n,
    input  wire        din,
    input  wire        self_test_in,
    input  wire [11:0] x_filter_node,
    input  wire [11:0] y_filter_node,
    input  wire [9:0]  temp_code,
    output reg         dout,
    output reg         dout_oe,
    output reg         axis_select_bit,
    output reg         power_mode_bit,
    output reg  [7:0]  accel_ctrl_word,
    output reg  [7:0]  temp_ctrl_word
);

// ==========================================================
// Frame states, one-hot
// ==========================================================
localparam [2:0] ST_IDLE  = 3'h1;   // Nothing selected
localparam [2:0] ST_ACCEL = 3'h2;   // Accelerometer frame running
localparam [2:0] ST_TEMP  = 3'h4;   // Temperature frame running

localparam SYNC_W = 39;             // Width of the synchronised bundle

// ==========================================================
// Bit decoders
// ==========================================================
// Accelerometer output bit for a frame position, zeros first
function acc_bit;
    input [3:0]  idx;
    input [11:0] code;
    reg   [3:0]  pos;
    begin
        pos = `ACC_MSB_INDEX - idx;
        if (idx < `ACC_LEAD_ZEROS) begin
            acc_bit = 1'b0;
        end else begin
            acc_bit = code[pos];
        end
    end
endfunction

// Temperature output bit: leading zero, then ten bits MSB first
function tmp_bit;
    input [3:0] idx;
    input [9:0] code;
    reg   [3:0] pos;
    begin
        pos = `TMP_LAST_INDEX - idx;
        if (idx == 4'h0) begin
            tmp_bit = 1'b0;
        end else begin
            tmp_bit = code[pos];
        end
    end
endfunction

// ==========================================================
// Input synchronisation
// ==========================================================
wire [SYNC_W-1:0] sync_w;           // Synchronised pins and sensor codes
wire              sclk_s;           // Serial clock level
wire              cs_n_s;           // Accelerometer select, active low
wire              tcs_n_s;          // Temperature select, active low
wire              din_s;            // Serial data input
wire              st_s;             // Self-test level
wire [11:0]       x_s;              // X axis code
wire [11:0]       y_s;              // Y axis code
wire [9:0]        t_s;              // Temperature code

// All pins and analog-side codes pass two flops first
// Sensor words carry no handshake; hold them steady across a frame
pin_sync #(
    .WIDTH    (SYNC_W)
) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({sclk, cs_n, temp_select_n, din, self_test_in,
                x_filter_node, y_filter_node, temp_code}),
    .sync_out (sync_w)
);

assign sclk_s  = sync_w[38];
assign cs_n_s  = sync_w[37];
assign tcs_n_s = sync_w[36];
assign din_s   = sync_w[35];
assign st_s    = sync_w[34];
assign x_s     = sync_w[33:22];
assign y_s     = sync_w[21:10];
assign t_s     = sync_w[9:0];

// ==========================================================
// Edge detection
// ==========================================================
reg  sclk_prev_reg;                 // Serial clock one cycle back
reg  cs_prev_reg;                   // Accelerometer select one cycle back
reg  tcs_prev_reg;                  // Temperature select one cycle back
wire sclk_rise;                     // Serial clock rising edge
wire sclk_fall;                     // Serial clock falling edge
wire accel_sel;                     // Only the accelerometer is selected
wire temp_sel;                      // Only the temperature sensor is selected
wire cs_fall;                       // Accelerometer select went low
wire tcs_fall;                      // Temperature select went low

// Delayed copies for edge finding
always @(posedge sys_clk) begin
    if (!rst_n) begin
        sclk_prev_reg <= 1'b0;
        // Cleared like the synchroniser, so no select edge at release
        cs_prev_reg   <= 1'b0;
        tcs_prev_reg  <= 1'b0;
    end else begin
        sclk_prev_reg <= sclk_s;
        cs_prev_reg   <= cs_n_s;
        tcs_prev_reg  <= tcs_n_s;
    end
end

assign sclk_rise = sclk_s & ~sclk_prev_reg;
assign sclk_fall = ~sclk_s & sclk_prev_reg;
assign accel_sel = ~cs_n_s & tcs_n_s;
assign temp_sel  = ~tcs_n_s & cs_n_s;
assign cs_fall   = ~cs_n_s & cs_prev_reg;
assign tcs_fall  = ~tcs_n_s & tcs_prev_reg;

// ==========================================================
// Axis selection and self-test offset
// ==========================================================
wire [11:0] raw_sel;                // Code of the addressed axis
wire [11:0] adj_sel;                // Code after self-test shift

assign raw_sel = axis_select_bit ? y_s : x_s;

accel_code_adjust #(
    .ST_SHIFT  (`ST_DELTA)
) u_adjust (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .raw_code  (raw_sel),
    .self_test (st_s),
    .adj_code  (adj_sel)
);

// ==========================================================
// Frame engine
// ==========================================================
reg  [2:0]  state_reg;              // One-hot frame state
reg  [3:0]  cnt_reg;                // Rising edges seen in this frame
reg  [6:0]  shift_reg;              // Control bits gathered so far
reg  [11:0] sample_reg;             // Acceleration sample being shifted
reg  [9:0]  temp_reg;               // Temperature value being shifted
reg         wake_reg;               // Wake requested, due on last rise
wire [7:0]  word_w;                 // Control word on its eighth rise
wire        at_sample_rise;         // Rise that takes the acceleration sample
wire        at_load_rise;           // Rise that completes the control word
wire        at_last_rise;           // Sixteenth rise, closes the frame
wire        wake_due;               // Shutdown ends on this rise

// ==========================================================
// Frame position decode
// ==========================================================
// Positions count the rises already seen in this frame
assign at_sample_rise = (cnt_reg == `SAMPLE_RISE);
assign at_load_rise   = (cnt_reg == `CTRL_LOAD_RISE);
assign at_last_rise   = (cnt_reg == `LAST_RISE);
assign wake_due       = at_last_rise & wake_reg;

assign word_w = {shift_reg, din_s};

// Framing, capture of control words and serial output
always @(posedge sys_clk) begin
    if (!rst_n) begin
        state_reg       <= ST_IDLE;
        cnt_reg         <= 4'h0;
        shift_reg       <= 7'h00;
        sample_reg      <= `ZERO_G_CODE;
        temp_reg        <= 10'h000;
        wake_reg        <= 1'b0;
        dout            <= 1'b0;
        dout_oe         <= 1'b0;
        axis_select_bit <= 1'b0;
        power_mode_bit  <= 1'b0;
        accel_ctrl_word <= `CTRL_RESET;
        temp_ctrl_word  <= `TCTRL_RESET;
    end else begin
        case (state_reg)
            ST_IDLE: begin
                // A select fall counts only while the other select is high
                if (cs_fall && accel_sel) begin
                    // New conversion and transfer, first pad bit out
                    state_reg <= ST_ACCEL;
                    cnt_reg   <= 4'h0;
                    dout      <= 1'b0;
                    dout_oe   <= 1'b1;
                end else if (tcs_fall && temp_sel) begin
                    // Freeze the temperature, leading zero out
                    state_reg <= ST_TEMP;
                    cnt_reg   <= 4'h0;
                    temp_reg  <= t_s;
                    dout      <= 1'b0;
                    dout_oe   <= 1'b1;
                end
            end
            ST_ACCEL: begin
                if (!accel_sel) begin
                    // Select released or both selects low
                    state_reg <= ST_IDLE;
                    dout_oe   <= 1'b0;
                end else if (sclk_rise) begin
                    // Every din bit shifts; only the eighth rise loads it
                    shift_reg <= word_w[6:0];
                    // Second rise takes the sample unless shut down
                    if (at_sample_rise && !power_mode_bit) begin
                        sample_reg <= adj_sel;
                    end
                    // Eighth rise loads the control word
                    if (at_load_rise) begin
                        accel_ctrl_word <= word_w;
                        axis_select_bit <= word_w[`AXIS_BIT];
                        if (word_w[`PM_BIT]) begin
                            power_mode_bit <= 1'b1;
                            wake_reg       <= 1'b0;
                        end else if (power_mode_bit) begin
                            wake_reg <= 1'b1;
                        end
                    end
                    // Last rise closes the frame; wrap restarts it
                    if (wake_due) begin
                        power_mode_bit <= 1'b0;
                        wake_reg       <= 1'b0;
                    end
                    cnt_reg <= cnt_reg + 4'h1;
                end else if (sclk_fall) begin
                    dout <= acc_bit(cnt_reg, sample_reg);
                end
            end
            ST_TEMP: begin
                if (!temp_sel) begin
                    // Release when the select rises or both selects are low
                    state_reg <= ST_IDLE;
                    dout_oe   <= 1'b0;
                end else if (sclk_rise) begin
                    shift_reg <= word_w[6:0];
                    if (at_load_rise) begin
                        temp_ctrl_word <= word_w;
                    end
                    // Rises past the sixteenth leave the count parked
                    if (!at_last_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end else if (sclk_fall) begin
                    // Past the last bit the line holds its level
                    if (cnt_reg <= `TMP_LAST_INDEX) begin
                        dout <= tmp_bit(cnt_reg, temp_reg);
                    end
                end
            end
            default: begin
                // Unknown state code falls back to idle
                state_reg <= ST_IDLE;
                dout_oe   <= 1'b0;
            end
        endcase
    end
end

endmodule

// *** rtl/pin_sync.v ***
// Two-stage synchroniser for inputs arriving from outside sys_clk
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

// ==========================================================
// Synchroniser stages
// ==========================================================
reg [WIDTH-1:0] meta_reg;   // First stage, read only by the second

// Both stages clear under reset, then follow the pins
always @(posedge sys_clk) begin
    if (!rst_n) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
end

endmodule

// *** verification/accel_readout_monitor.sv ***
// Concurrent checks on the readout port pins
`timescale 1ns/1ps
`include "accel_readout_consts.vh"
module accel_readout_monitor (
    input wire       sys_clk,
    input wire       rst_n,
    input wire       sclk,
    input wire       cs_n,
    input wire       temp_select_n,
    input wire       dout,
    input wire       dout_oe,
    input wire       axis_select_bit,
    input wire       power_mode_bit,
    input wire [7:0] accel_ctrl_word,
    input wire [7:0] temp_ctrl_word
);
    reg [3:0] since_fall; // Cycles since the serial clock last fell
    // ====================
    // Helper counter
    always @(posedge sys_clk) begin
        if (!rst_n || $fell(sclk))
            since_fall <= 4'h0;
        else if (since_fall != 4'hF)
            since_fall <= since_fall + 4'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ====================
    // Properties
    property p_oe_on;
        $fell(cs_n) && temp_select_n |-> ##[1:6] dout_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("select fall not answered");
    property p_oe_off;
        (cs_n && temp_select_n) [*4] |=> !dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("output driven while idle");
    property p_oe_cause;
        $rose(dout_oe) |-> !$past(cs_n, 2) || !$past(temp_select_n, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("output enabled without select");
    property p_lead_zero;
        $rose(dout_oe) |-> !dout;
    endproperty
    a_lead_zero: assert property (p_lead_zero)
        else $error("first bit not zero");
    property p_bit_on_fall;
        dout_oe && $past(dout_oe) && $changed(dout) |-> since_fall <= 4'h6;
    endproperty
    a_bit_on_fall: assert property (p_bit_on_fall)
        else $error("output changed away from clock fall");
    property p_axis;
        axis_select_bit == accel_ctrl_word[`AXIS_BIT];
    endproperty
    a_axis: assert property (p_axis)
        else $error("axis differs from control word");
    property p_pm_on;
        $changed(accel_ctrl_word) && accel_ctrl_word[`PM_BIT] |-> ##[0:1] power_mode_bit;
    endproperty
    a_pm_on: assert property (p_pm_on)
        else $error("shutdown not entered at load");
    property p_pm_off;
        $fell(power_mode_bit) |-> !accel_ctrl_word[`PM_BIT] && !cs_n;
    endproperty
    a_pm_off: assert property (p_pm_off)
        else $error("wake without cleared mode bit");
    property p_ctrl_load;
        $changed(accel_ctrl_word) |-> !$past(cs_n, 4) && temp_select_n;
    endproperty
    a_ctrl_load: assert property (p_ctrl_load)
        else $error("control word changed outside frame");
    property p_temp_ctrl;
        $changed(temp_ctrl_word) |-> !$past(temp_select_n, 4) && cs_n;
    endproperty
    a_temp_ctrl: assert property (p_temp_ctrl)
        else $error("temperature word changed outside frame");
    c_accel: cover property ($rose(dout_oe) && !cs_n);
    c_shut: cover property ($rose(power_mode_bit));
    c_wake: cover property ($fell(power_mode_bit));
endmodule

// *** verification/serial_host.sv ***
// Host serial master model driving the readout pins
`timescale 1ns/1ps
module serial_host (
    input  wire sys_clk,
    input  wire dout,
    input  wire dout_oe,
    output reg  sclk,
    output reg  cs_n,
    output reg  temp_select_n,
    output reg  din
);
    // Idle: selects high, clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        temp_select_n = 1'b1;
        din = 1'b0;
    end
    // One 16-clock frame; keep leaves the select low
    task automatic xfer(input tsel, input keep, input [7:0] w, output [15:0] rx);
        integer k;
        begin
            if (cs_n && temp_select_n) begin
                if (tsel) // Only one select at a time
                    temp_select_n <= 1'b0;
                else
                    cs_n <= 1'b0;
                repeat (8) @(posedge sys_clk);
            end
            for (k = 0; k < 16; k = k + 1) begin // Full burst
                din <= (k < 8) ? w[7 - k] : 1'b0;
                repeat (4) @(posedge sys_clk);
                sclk <= 1'b1;
                rx[15 - k] = dout_oe ? dout : 1'bx; // Taken at the rise
                repeat (4) @(posedge sys_clk);
                sclk <= 1'b0;
            end
            if (!keep) begin
                cs_n <= 1'b1;
                temp_select_n <= 1'b1;
                din <= 1'b0;
                repeat (3880) @(posedge sys_clk); // Rate at most 10 kSPS
            end
        end
    endtask
endmodule

// *** verification/test_accel_serial_readout.sv ***
// Self-checking bench for the accelerometer serial readout
`timescale 1ns/1ps
bind accel_serial_readout accel_readout_monitor accel_readout_monitor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .temp_select_n(temp_select_n), .dout(dout), .dout_oe(dout_oe),
    .axis_select_bit(axis_select_bit), .power_mode_bit(power_mode_bit),
    .accel_ctrl_word(accel_ctrl_word), .temp_ctrl_word(temp_ctrl_word));
module test_accel_serial_readout;
    reg          sys_clk;
    reg          rst_n;
    reg          self_test_in;
    reg   [11:0] x_filter_node;
    reg   [11:0] y_filter_node;
    reg   [9:0]  temp_code;
    wire         sclk, cs_n, temp_select_n, din, dout, dout_oe;
    wire         axis_select_bit, power_mode_bit;
    wire  [7:0]  accel_ctrl_word, temp_ctrl_word;
    reg   [15:0] rx;
    integer      n_fail, tests_run, cycles;
    accel_serial_readout accel_serial_readout_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .temp_select_n(temp_select_n), .din(din), .self_test_in(self_test_in),
        .x_filter_node(x_filter_node), .y_filter_node(y_filter_node),
        .temp_code(temp_code), .dout(dout), .dout_oe(dout_oe),
        .axis_select_bit(axis_select_bit), .power_mode_bit(power_mode_bit),
        .accel_ctrl_word(accel_ctrl_word), .temp_ctrl_word(temp_ctrl_word));
    serial_host serial_host_i (
        .sys_clk(sys_clk), .dout(dout), .dout_oe(dout_oe), .sclk(sclk),
        .cs_n(cs_n), .temp_select_n(temp_select_n), .din(din));
    // ====================
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 45000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
    // ====================
    // Compare, frame and verdict helpers
    task check(input string what, input [15:0] got, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task acc(input [7:0] w, input keep, input [15:0] exp);
        begin
            serial_host_i.xfer(1'b0, keep, w, rx);
            check("accel frame", rx, exp);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // ====================
    // Main sequence
    initial begin
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        rst_n = 1'b0;
        self_test_in = 1'b0;
        x_filter_node = 12'h800;
        y_filter_node = 12'hD00;
        temp_code = 10'h365;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check("ctrl reset", {8'h00, accel_ctrl_word}, 16'h0004);
        check("temp reset", {8'h00, temp_ctrl_word}, 16'h0000);
        check("oe idle", {15'h0000, dout_oe}, 16'h0000);
        acc(8'h0C, 1'b0, 16'h0800);
        check("axis", {15'h0000, axis_select_bit}, 16'h0001);
        acc(8'h84, 1'b0, 16'h0D00);
        check("ctrl", {8'h00, accel_ctrl_word}, 16'h0084);
        check("oe released", {15'h0000, dout_oe}, 16'h0000);
        x_filter_node <= 12'h300;
        self_test_in <= 1'b1;
        acc(8'h04, 1'b1, 16'h03CD);
        x_filter_node <= 12'hFF0;
        acc(8'h04, 1'b0, 16'h0FFF);
        self_test_in <= 1'b0;
        x_filter_node <= 12'h123;
        acc(8'h05, 1'b0, 16'h0123);
        check("pm on", {15'h0000, power_mode_bit}, 16'h0001);
        check("ctrl kept", {8'h00, accel_ctrl_word}, 16'h0005);
        x_filter_node <= 12'h456;
        acc(8'h04, 1'b0, 16'h0123);
        check("pm off", {15'h0000, power_mode_bit}, 16'h0000);
        acc(8'h04, 1'b0, 16'h0456);
        serial_host_i.xfer(1'b1, 1'b0, 8'h00, rx);
        check("temp", rx, {1'b0, 10'h365, 5'h1F});
        temp_code <= 10'h064;
        repeat (4) @(posedge sys_clk);
        serial_host_i.xfer(1'b1, 1'b0, 8'hA5, rx);
        check("temp pos", rx, {1'b0, 10'h064, 5'h00});
        check("temp ctrl", {8'h00, temp_ctrl_word}, 16'h00A5);
        check("oe end", {15'h0000, dout_oe}, 16'h0000);
        tally_and_finish;
    end
endmodule
